// ### adcm_pkg.sv
package adcm_pkg;
  localparam int          NUM_CHAN        = 4;
  localparam int          ADDR_W          = 8;
  // Word indices; byte address is four times the index
  localparam logic [5:0]  IDX_STATUS      = 6'h01;
  localparam logic [5:0]  IDX_MODE        = 6'h02;
  localparam logic [5:0]  IDX_CLOCK       = 6'h03;
  localparam logic [5:0]  IDX_DATA0       = 6'h10;
  localparam logic [15:0] MODE_RESET      = 16'h0510;
  localparam logic [15:0] CLOCK_RESET     = 16'h0f0e;
  localparam logic [15:0] CLOCK_RW_MASK   = 16'h0fff;
  localparam logic [15:0] MODE_STORE_MASK = 16'hfbff;
  localparam int          MODE_REGCRC     = 13;
  localparam int          MODE_RXCRC      = 12;
  localparam int          MODE_POLY       = 11;
  localparam int          MODE_RSTSEEN    = 10;
  localparam int          MODE_WLEN_LO    = 8;
  localparam int          MODE_TIMEOUT    = 4;
  localparam int          MODE_SRC_LO     = 2;
  localparam int          MODE_FLOAT      = 1;
  localparam int          MODE_PULSE      = 0;
  localparam int          CLOCK_EN_LO     = 8;
  localparam int          STAT_CRCERR     = 12;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
  localparam int          CLK_MHZ         = 200;
  localparam int          PULSE_NS        = 20;
  localparam int          PULSE_CYCLES    = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0]  WLEN_16         = 2'b00;
  localparam logic [1:0]  WLEN_24         = 2'b01;
  localparam logic [1:0]  WLEN_32_PAD     = 2'b10;
  localparam logic [1:0]  WLEN_32_SIGN    = 2'b11;
  localparam logic [1:0]  SRC_LAGGING     = 2'b00;
  localparam logic [1:0]  SRC_ANY         = 2'b01;
endpackage : adcm_pkg

// ### adcm_ready_pin.sv
`timescale 1ns/1ps
module adcm_ready_pin (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic ce,
  input  wire logic avail,
  input  wire logic ready_idle_float,
  input  wire logic ready_pulse_format,
  output logic      ready_pin_o,
  output logic      ready_pin_oe
);
  import adcm_pkg::*;
  logic       avail_q;
  logic [7:0] pulse_cnt;
  wire        rise = avail & ~avail_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avail_q   <= 1'b0;
      pulse_cnt <= 8'h00;
    end else if (ce) begin
      avail_q <= avail;
      // Pulse runs its full length even if data are read early
      if (rise && ready_pulse_format) begin
        pulse_cnt <= 8'(PULSE_CYCLES);
      end else if (pulse_cnt != 8'h00) begin
        pulse_cnt <= pulse_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ready_pin_o  <= 1'b1;
      ready_pin_oe <= 1'b1;
    end else if (ce) begin
      if (ready_pulse_format ? (rise || pulse_cnt > 8'h01) : avail) begin
        ready_pin_o  <= 1'b0;
        ready_pin_oe <= 1'b1;
      end else begin
        ready_pin_o  <= 1'b1;
        ready_pin_oe <= ~ready_idle_float;
      end
    end
  end
endmodule : adcm_ready_pin

// ### adcm_regs.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module adcm_regs (
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  input  wire logic                     ce,
  input  wire logic [adcm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [adcm_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [3:0]               sample_valid,
  input  wire logic [95:0]              sample_data,
  input  wire logic                     frame_crc_error,
  output logic                          reg_crc_enable,
  output logic                          rx_crc_enable,
  output logic                          crc_poly_ansi,
  output logic                          timeout_enable,
  output logic [3:0]                    channel_adc_on,
  output logic                          ready_pin_o,
  output logic                          ready_pin_oe
);
  import adcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] mode_config;
  logic        reset_seen;
  logic [15:0] clock_config;
  logic [3:0]  data_ready;
  logic        crc_err_flag;
  logic [23:0] chan_sample [NUM_CHAN];
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [31:0] fmt_word;
  logic [23:0] rd_sample;
  logic [15:0] status_flags;
  logic [15:0] mode_view;
  logic        avail;
  logic [3:0]  en_ready;

  function automatic logic [15:0] merge_strb(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    merge_strb = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge_strb

  function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[7:2];
  endfunction : word_idx

  function automatic logic is_data_idx(input logic [5:0] i);
    is_data_idx = (i >= IDX_DATA0) && (i < IDX_DATA0 + 6'(NUM_CHAN));
  endfunction : is_data_idx

  wire [5:0] wr_idx   = word_idx(aw_addr);
  wire [5:0] rd_idx   = word_idx(s_axi_araddr);
  wire       do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire       rd_take  = s_axi_arvalid & s_axi_arready;
  wire [1:0] rd_chan  = 2'(rd_idx - IDX_DATA0);

  assign mode_view    = (mode_config & MODE_STORE_MASK) | (16'(reset_seen) << MODE_RSTSEEN);
  assign status_flags = {3'b000, crc_err_flag, mode_view[MODE_POLY], reset_seen,
                         mode_view[9:8], 4'h0, data_ready};
  assign rd_sample    = chan_sample[rd_chan];

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx == IDX_MODE || wr_idx == IDX_CLOCK) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and clock words
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_config <= MODE_RESET;
    end else if (ce && do_write && wr_idx == IDX_MODE) begin
      // Reserved bits are stored as written; host keeps them zero
      mode_config <= merge_strb(mode_config, w_data, w_strb);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reset_seen <= 1'b1;
    end else if (ce && do_write && wr_idx == IDX_MODE && w_strb[1] && !w_data[MODE_RSTSEEN]) begin
      reset_seen <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clock_config <= CLOCK_RESET;
    end else if (ce && do_write && wr_idx == IDX_CLOCK) begin
      clock_config <= merge_strb(clock_config, w_data, w_strb) & CLOCK_RW_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample capture and fresh-data flags; arrival beats a clearing read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_sample[i] <= 24'h00_0000;
      end
    end else if (ce) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (sample_valid[i]) begin
          chan_sample[i] <= sample_data[i*24 +: 24];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      data_ready <= 4'h0;
    end else if (ce) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (sample_valid[i]) begin
          data_ready[i] <= 1'b1;
        end else if (rd_take && is_data_idx(rd_idx) && rd_chan == 2'(i)) begin
          data_ready[i] <= 1'b0;
        end
      end
    end
  end

  // Sticky until status is read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      crc_err_flag <= 1'b0;
    end else if (ce) begin
      if (frame_crc_error && mode_config[MODE_RXCRC]) begin
        crc_err_flag <= 1'b1;
      end else if (rd_take && rd_idx == IDX_STATUS) begin
        crc_err_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: answer one cycle after the address is taken
  adcm_word_fmt u_fmt (
    .sample           (rd_sample),
    .word_size_select (mode_config[9:8]),
    .word             (fmt_word)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        if (rd_idx == IDX_STATUS) begin
          s_axi_rdata <= {16'h0000, status_flags};
        end else if (rd_idx == IDX_MODE) begin
          s_axi_rdata <= {16'h0000, mode_view};
        end else if (rd_idx == IDX_CLOCK) begin
          s_axi_rdata <= {16'h0000, clock_config};
        end else if (is_data_idx(rd_idx)) begin
          s_axi_rdata <= fmt_word;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_crc_enable <= 1'b0;
      rx_crc_enable  <= 1'b0;
      crc_poly_ansi  <= 1'b0;
      timeout_enable <= 1'b1;
      channel_adc_on <= 4'hf;
    end else if (ce) begin
      reg_crc_enable <= mode_config[MODE_REGCRC];
      rx_crc_enable  <= mode_config[MODE_RXCRC];
      crc_poly_ansi  <= mode_config[MODE_POLY];
      timeout_enable <= mode_config[MODE_TIMEOUT];
      channel_adc_on <= clock_config[CLOCK_EN_LO +: 4];
    end
  end

  // Simultaneous sampling: leading channel is the first to be ready
  assign en_ready = data_ready | ~clock_config[CLOCK_EN_LO +: 4];
  always_comb begin
    unique case (mode_config[MODE_SRC_LO +: 2])
      SRC_LAGGING: avail = (&en_ready) && (clock_config[CLOCK_EN_LO +: 4] != 4'h0);
      SRC_ANY:     avail = |(data_ready & clock_config[CLOCK_EN_LO +: 4]);
      default:     avail = |(data_ready & clock_config[CLOCK_EN_LO +: 4]);
    endcase
  end

  adcm_ready_pin u_pin (
    .clk_sys            (clk_sys),
    .arst_n             (arst_n),
    .ce                 (ce),
    .avail              (avail),
    .ready_idle_float   (mode_config[MODE_FLOAT]),
    .ready_pulse_format (mode_config[MODE_PULSE]),
    .ready_pin_o        (ready_pin_o),
    .ready_pin_oe       (ready_pin_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  property p_flag_set;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && sample_valid[0] |=> data_ready[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Flag not set by sample");

  property p_flag_clear;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && rd_take && rd_idx == IDX_DATA0 && !sample_valid[0] |=> !data_ready[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Flag not cleared by read");

  property p_regcrc_out;
    @(posedge clk_sys) disable iff (!arst_n)
      ce |=> reg_crc_enable == $past(mode_config[MODE_REGCRC]);
  endproperty
  a_regcrc_out: assert property (p_regcrc_out) else $error("Register CRC enable wrong");

  property p_crcerr_gate;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && !crc_err_flag && frame_crc_error && !mode_config[MODE_RXCRC] |=> !crc_err_flag;
  endproperty
  a_crcerr_gate: assert property (p_crcerr_gate) else $error("Error flagged while check off");

  property p_poly_status;
    @(posedge clk_sys) disable iff (!arst_n)
      status_flags[MODE_POLY] == mode_config[MODE_POLY];
  endproperty
  a_poly_status: assert property (p_poly_status) else $error("Polynomial mirror wrong");

  property p_reset_sticky;
    @(posedge clk_sys) disable iff (!arst_n)
      !reset_seen |=> !reset_seen;
  endproperty
  a_reset_sticky: assert property (p_reset_sticky) else $error("Reset flag reappeared");

  property p_word_pad;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && rd_take && is_data_idx(rd_idx) && mode_config[9:8] == WLEN_32_PAD
        |=> s_axi_rdata[7:0] == 8'h00;
  endproperty
  a_word_pad: assert property (p_word_pad) else $error("Zero padding missing");

  property p_timeout_out;
    @(posedge clk_sys) disable iff (!arst_n)
      ce ##1 ce |-> timeout_enable == $past(mode_config[MODE_TIMEOUT]);
  endproperty
  a_timeout_out: assert property (p_timeout_out) else $error("Timeout enable wrong");

  property p_float_idle;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && !avail && !mode_config[MODE_PULSE] && mode_config[MODE_FLOAT] |=> !ready_pin_oe;
  endproperty
  a_float_idle: assert property (p_float_idle) else $error("Idle pin not floated");

  property p_level_low;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && avail && !mode_config[MODE_PULSE] |=> !ready_pin_o && ready_pin_oe;
  endproperty
  a_level_low: assert property (p_level_low) else $error("Ready level not low");

  property p_clock_resv;
    @(posedge clk_sys) disable iff (!arst_n)
      clock_config[15:12] == 4'h0;
  endproperty
  a_clock_resv: assert property (p_clock_resv) else $error("Clock reserved bits set");

  property p_reset_clear;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && do_write && wr_idx == IDX_MODE && w_strb[1] && !w_data[MODE_RSTSEEN]
        |=> !status_flags[MODE_RSTSEEN];
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Reset flag not cleared");

  property p_any_src;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && !mode_config[MODE_PULSE] && mode_config[MODE_SRC_LO +: 2] == SRC_ANY
        && |(data_ready & clock_config[CLOCK_EN_LO +: 4]) |=> !ready_pin_o;
  endproperty
  a_any_src: assert property (p_any_src) else $error("Ready pin ignores enabled flag");

  property p_lead_src;
    @(posedge clk_sys) disable iff (!arst_n)
      mode_config[MODE_SRC_LO + 1] && |(data_ready & clock_config[CLOCK_EN_LO +: 4]) |-> avail;
  endproperty
  a_lead_src: assert property (p_lead_src) else $error("Leading source not selected");

  // Both edges must run so the pin's own history matches ours
  property p_pulse_start;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && $past(ce) && mode_config[MODE_PULSE] && avail && !$past(avail)
        |=> !ready_pin_o && ready_pin_oe;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("Ready pulse not started");

  property p_word_16;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && rd_take && is_data_idx(rd_idx) && mode_config[9:8] == WLEN_16
        |=> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_word_16: assert property (p_word_16) else $error("Short word not cleared above");

  property p_sign_ext;
    @(posedge clk_sys) disable iff (!arst_n)
      ce && rd_take && is_data_idx(rd_idx) && mode_config[9:8] == WLEN_32_SIGN
        |=> s_axi_rdata[31:24] == {8{s_axi_rdata[23]}};
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("Sign not extended");
endmodule : adcm_regs

// ### adcm_regs_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module adcm_regs_tb;
  import adcm_pkg::*;
  logic clk_sys, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, crc_err, reg_crc, rx_crc, poly, tmo, pin_o, pin_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  sval, chan_on, wstrb;
  logic [95:0] sdata;
  int          mismatches, cmp_count;
  adcm_regs dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_valid(sval), .sample_data(sdata), .frame_crc_error(crc_err),
    .reg_crc_enable(reg_crc), .rx_crc_enable(rx_crc), .crc_poly_ansi(poly),
    .timeout_enable(tmo), .channel_adc_on(chan_on), .ready_pin_o(pin_o), .ready_pin_oe(pin_oe));
  adcm_sample_src src_u (.clk_sys(clk_sys), .sample_valid(sval), .sample_data(sdata),
    .frame_crc_error(crc_err));
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // Bus cycles: hold each channel until its own handshake
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_sys);
    awaddr <= a; wdata <= {16'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp; bready <= 1'b0; break;
      end
    end
    if (n == 50) begin mismatches++; stop_test(); end
  endtask : wr
  task automatic rdw(input logic [7:0] a);
    int n;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rd = rdata; rs = rresp; rready <= 1'b0; break;
      end
    end
    if (n == 50) begin mismatches++; stop_test(); end
  endtask : rdw
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    rdw(a);
    `CHK(nm, e, rd)
  endtask : chk_rd
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_rd("mode", 8'h08, 32'h00000510);
    chk_rd("clock", 8'h0c, 32'h00000f0e);
    chk_rd("status", 8'h04, 32'h00000500);
    `CHK("outs", 5'b00011, {reg_crc, rx_crc, poly, tmo, pin_oe})
    `CHK("chan_on", 4'hf, chan_on)
  endtask : t_reset
  task automatic t_mode();
    // Low byte only: reset flag must survive
    wstrb <= 4'h1;
    wr(8'h08, 16'h0000);
    wstrb <= 4'hf;
    chk_rd("mode_lo", 8'h08, 32'h00000500);
    wr(8'h08, 16'h3b0f);
    chk_rd("mode", 8'h08, 32'h00003b0f);
    chk_rd("status", 8'h04, 32'h00000b00);
    `CHK("outs", 4'b1110, {reg_crc, rx_crc, poly, tmo})
    wr(8'h08, 16'h0510);
    #1;
    `CHK("poly", 3'b010, {poly, tmo, rx_crc})
    chk_rd("rst_seen", 8'h04, 32'h00000100);
  endtask : t_mode
  task automatic t_data();
    logic [31:0] tbl[4];
    tbl = '{32'h00008000, 32'h00800001, 32'h80000100, 32'hff800001};
    for (int k = 0; k < 4; k++) begin
      wr(8'h08, 16'h0010 | 16'(k << 8));
      src_u.fire(k, 24'h800001);
      repeat (2) @(posedge clk_sys);
      chk_rd("flag", 8'h04, 32'(k << 8) | 32'(1 << k));
      chk_rd("word", 8'h40 + 8'(4 * k), tbl[k]);
      chk_rd("flag_clr", 8'h04, 32'(k << 8));
    end
  endtask : t_data
  task automatic t_crc();
    src_u.crc_bad();
    chk_rd("crc_off", 8'h04, 32'h00000300);
    wr(8'h08, 16'h1110);
    src_u.crc_bad();
    chk_rd("crc_on", 8'h04, 32'h00001100);
    chk_rd("crc_clr", 8'h04, 32'h00000100);
  endtask : t_crc
  task automatic t_pin();
    src_u.fire(0, 24'h000123);
    repeat (4) @(posedge clk_sys); #1;
    `CHK("lag_wait", 2'b11, {pin_o, pin_oe})
    wr(8'h0c, 16'h010e);
    repeat (3) @(posedge clk_sys); #1;
    `CHK("lag_one", 6'b000101, {chan_on, pin_o, pin_oe})
    wr(8'h08, 16'h0114);
    chk_rd("drain", 8'h40, 32'h00000123);
    repeat (3) @(posedge clk_sys); #1;
    `CHK("idle_hi", 2'b11, {pin_o, pin_oe})
    wr(8'h08, 16'h0116);
    repeat (3) @(posedge clk_sys); #1;
    `CHK("idle_lz", 2'b10, {pin_o, pin_oe})
    wr(8'h08, 16'h011f);
    repeat (3) @(posedge clk_sys); #1;
    `CHK("idle_z", 1'b0, pin_oe)
    // Last low cycle, then released
    src_u.fire(0, 24'h000456);
    repeat (PULSE_CYCLES) @(posedge clk_sys); #1;
    `CHK("pulse", 2'b01, {pin_o, pin_oe})
    @(posedge clk_sys); #1;
    `CHK("pulse_end", 2'b10, {pin_o, pin_oe})
    repeat (PULSE_CYCLES + 4) @(posedge clk_sys); #1;
    `CHK("pulse_once", 1'b0, pin_oe && !pin_o)
  endtask : t_pin
  task automatic t_bad();
    chk_rd("unmapped", 8'h14, 32'h0);
    `CHK("rresp", RESP_SLVERR, rs)
    wr(8'h04, 16'hffff);
    `CHK("bresp_ro", RESP_SLVERR, rs)
  endtask : t_bad
  ////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0;
    wstrb = 4'hf;
    mismatches = 0; cmp_count = 0;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_mode();
    t_data();
    t_crc();
    t_pin();
    t_bad();
    stop_test();
  end
endmodule : adcm_regs_tb

// ### adcm_sample_src.sv
`timescale 1ns/1ps
module adcm_sample_src (
  input  wire logic        clk_sys,
  output logic [3:0]       sample_valid,
  output logic [95:0]      sample_data,
  output logic             frame_crc_error
);
  initial begin
    sample_valid    = 4'h0;
    sample_data     = 96'h0;
    frame_crc_error = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Fresh conversion result, one-cycle strobe
  task automatic fire(input int ch, input logic [23:0] v);
    @(posedge clk_sys);
    sample_data[ch*24 +: 24] <= v;
    sample_valid[ch]         <= 1'b1;
    @(posedge clk_sys);
    sample_valid             <= 4'h0;
    // Stale bus: inverted so a late capture shows up
    sample_data[ch*24 +: 24] <= ~v;
  endtask : fire
  task automatic crc_bad();
    @(posedge clk_sys);
    frame_crc_error <= 1'b1;
    @(posedge clk_sys);
    frame_crc_error <= 1'b0;
  endtask : crc_bad
endmodule : adcm_sample_src

// ### adcm_word_fmt.sv
`timescale 1ns/1ps
module adcm_word_fmt (
  input  wire logic [23:0] sample,
  input  wire logic [1:0]  word_size_select,
  output logic      [31:0] word
);
  import adcm_pkg::*;
  always_comb begin
    unique case (word_size_select)
      WLEN_16:     word = {16'h0000, sample[23:8]};
      WLEN_24:     word = {8'h00, sample};
      WLEN_32_PAD: word = {sample, 8'h00};
      WLEN_32_SIGN: word = {{8{sample[23]}}, sample};
    endcase
  end
endmodule : adcm_word_fmt
